// [rtl/spcmd_decoder.sv]
// special command decoder: join control, key handling and factory restore
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - write-only command register at 0xc7 triggers operations, stores nothing
// - 0x10 join control, 0x11 key write, 0x12 key clear
// - 0x13 key reload; on serial only 0x20 0xaa 0xbb restores factory defaults
// - join sub 0 halts, 1 makes admin with new key, 2 joins
// - serially started join blocks push-button join requests until it ends
// - during a join all register writes are rejected except halt-join; here the 0x10 opcode byte in front of the halt also passes
// - halt-join completes before its acknowledge is returned; here the halt pulse and the ack share one cycle, the ack does not wait
// - key receiver flag chooses role and key rights at join start
// - after successful join copy stored address registers to volatile ones
// - key write is 0x11, select byte, then sixteen key bytes in order
// - select 0x01 targets runtime key, 0x02 the stored key
// - runtime key lost on reset and loaded from stored key at power-up
// - an all-zero key means no key is present
// - key clear zeroes runtime key on 0x01, stored key on 0x02
// - key reload copies stored key into the runtime key slot
// - factory restore returns every stored register to defaults
// - after restore send reset message on serial, then full reset
// - push-button restore pattern also triggers the factory restore
// - serial join operations behave like push-button join operations
module spcmd_decoder (
    // clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    // register writes from the frame parser
    input  wire spcmd_pkg::spcmd_wr_s  wr_i,
    output logic                       wr_reject_o,
    output logic                       ack_o,
    // push-button requests, already decoded
    input  wire logic                  pb_join_raw_i,
    input  wire logic                  pb_restore_raw_i,
    // join engine
    input  wire logic                  key_receiver_flag_i,
    input  wire logic                  join_busy_i,
    input  wire logic                  join_ok_i,
    output logic                       join_halt_o,
    output logic                       join_admin_o,
    output logic                       join_start_o,
    output logic                       join_as_admin_o,
    output logic                       addr_copy_o,
    // stored key memory
    input  wire logic [127:0]          stored_key_i,
    output logic [127:0]               stored_key_o,
    output logic                       stored_key_we_o,
    output logic [127:0]               runtime_key_o,
    output logic                       runtime_key_set_o,
    output logic                       stored_key_set_o,
    // factory restore and message
    output logic                       nv_restore_o,
    output logic [7:0]                 tx_data_o,
    output logic                       tx_valid_o,
    input  wire logic                  tx_ready_i,
    output logic                       sys_reset_o
);
    import spcmd_pkg::*;

    spcmd_state_e   state_q, state_d;
    logic [127:0]   rkey_q, skey_q, shift_q;
    logic [7:0]     sel_q;
    logic [4:0]     cnt_q;
    logic           loaded_q, serial_join_q, busy_q;
    logic           pbj_m_q, pbj_q, pbr_m_q, pbr_q, pbj_prev_q;
    logic           join_admin_role_q, sys_reset_q;
    logic           msg_done_q;

    // the block sits behind the frame parser: every byte of a frame that
    // is addressed to the command register arrives as one write strobe.
    // the register holds nothing readable; a byte either moves the
    // sequencer along or fires a one-cycle pulse towards the join engine,
    // the key store or the restore logic.
    //
    // hazards worth knowing:
    // - the join engine owns the link while busy, so writes are refused
    //   then, but a halt frame must still get through
    // - a refused byte that ends a frame must still drop the partial
    //   command, or the sequencer would wait in a sub-state for ever
    // - the restore message is sent once; the sequencer then parks until
    //   the system reset that it requests comes back as rst_i

    // message text is a constant table, no file needed
    localparam logic [8*23-1:0] MSG =
        {8'h0d, 8'h0a, "Configuration Reset", 8'h0d, 8'h0a};

    // accepted write strobes
    wire hit     = wr_i.valid && (wr_i.addr == SPCMD_REG_ADDR);
    wire is_halt = (state_q == SPCMD_JSUB) && (wr_i.data == SPCMD_JOIN_HALT);
    // the join-control opcode byte has to pass while busy, or the halt
    // subcommand behind it could never be reached
    wire is_jctl = (state_q == SPCMD_IDLE) &&
                   (wr_i.data == SPCMD_JOIN_CTRL);
    wire blocked = join_busy_i && !is_halt && !is_jctl;
    wire take    = hit && !blocked;
    wire sel_ok  = (wr_i.data == SPCMD_SEL_RUNTIME) ||
                   (wr_i.data == SPCMD_SEL_STORED);
    wire pb_join = pbj_q && !pbj_prev_q && !serial_join_q;
    // message stops after the last byte so the text is sent only once
    wire in_msg  = (state_q == SPCMD_MSG) && !msg_done_q;
    wire msg_adv = in_msg && tx_ready_i;
    wire restore_go = (take && state_q == SPCMD_RST2 &&
                       wr_i.data == SPCMD_RESTORE_2) ||
                      (pbr_q && state_q == SPCMD_IDLE);

    assign wr_reject_o  = hit && blocked;
    // halt pulse and its ack share the same cycle, so halt never lags the ack
    assign ack_o        = take;
    assign join_halt_o  = take && is_halt;
    assign join_admin_o = take && state_q == SPCMD_JSUB &&
                          wr_i.data == SPCMD_JOIN_ADMIN;
    assign join_start_o = (take && state_q == SPCMD_JSUB &&
                           wr_i.data == SPCMD_JOIN_RUN) ||
                          (pb_join && !join_busy_i);
    assign join_as_admin_o = join_admin_role_q;
    assign addr_copy_o  = busy_q && !join_busy_i && join_ok_i;
    assign nv_restore_o = restore_go;
    assign runtime_key_o     = rkey_q;
    assign stored_key_o      = skey_q;
    assign runtime_key_set_o = (rkey_q != SPCMD_KEY_ZERO);
    assign stored_key_set_o  = (skey_q != SPCMD_KEY_ZERO);
    assign tx_valid_o   = in_msg;
    assign tx_data_o    = MSG[8*(SPCMD_MSG_LEN-1-int'(cnt_q)) +: 8];
    assign sys_reset_o  = sys_reset_q;

    // command sequencing
    always_comb begin
        state_d = state_q;
        if (restore_go) begin
            state_d = SPCMD_MSG;
        end else if (take) begin
            unique case (state_q)
                SPCMD_IDLE: begin
                    unique case (wr_i.data)
                        SPCMD_JOIN_CTRL:  state_d = SPCMD_JSUB;
                        SPCMD_KEY_WRITE:  state_d = SPCMD_KSEL;
                        SPCMD_KEY_CLEAR:  state_d = SPCMD_CSEL;
                        SPCMD_RESTORE_0:  state_d = SPCMD_RST1;
                        default:          state_d = SPCMD_IDLE;
                    endcase
                end
                SPCMD_KSEL: state_d = sel_ok ? SPCMD_KDATA : SPCMD_IDLE;
                SPCMD_KDATA: begin
                    if (cnt_q == SPCMD_KEY_LAST) begin
                        state_d = SPCMD_IDLE;
                    end
                end
                SPCMD_RST1: state_d = (wr_i.data == SPCMD_RESTORE_1) ?
                                      SPCMD_RST2 : SPCMD_IDLE;
                SPCMD_MSG:  state_d = SPCMD_MSG;
                default:    state_d = SPCMD_IDLE;
            endcase
        end
        // a frame ending mid-sequence drops the partial command,
        // refused bytes included, so no stale sub-state survives a frame
        if (hit && wr_i.last && state_d != SPCMD_MSG) begin
            state_d = SPCMD_IDLE;
        end
    end

    // state, counters and message sender
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q     <= SPCMD_IDLE;
            cnt_q       <= 5'h00;
            sel_q       <= 8'h00;
            sys_reset_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            sys_reset_q <= msg_adv && cnt_q == SPCMD_MSG_LAST;
            if (take && state_q == SPCMD_KSEL) begin
                sel_q <= wr_i.data;
            end
            if (restore_go || (take && state_q == SPCMD_KSEL)) begin
                cnt_q <= 5'h00;
            end else if ((take && state_q == SPCMD_KDATA) || msg_adv) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // message end marker; without it the counter would wrap and the
    // text plus the reset request would repeat while waiting for rst_i
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            msg_done_q <= 1'b0;
        end else if (msg_adv && cnt_q == SPCMD_MSG_LAST) begin
            msg_done_q <= 1'b1;
        end
    end

    // the push-button lines come from outside the clock domain, so only
    // the second flop of each pair is read by any logic; the join line
    // also keeps a delayed copy for its rising-edge detect, reset to the
    // idle level of the pin so no false edge follows reset
    // two-flop synchronisers for the push-button requests
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {pbj_m_q, pbj_q, pbj_prev_q} <= 3'h0;
            {pbr_m_q, pbr_q}             <= 2'h0;
        end else begin
            pbj_m_q    <= pb_join_raw_i;
            pbj_q      <= pbj_m_q;
            pbj_prev_q <= pbj_q;
            pbr_m_q    <= pb_restore_raw_i;
            pbr_q      <= pbr_m_q;
        end
    end

    // the serial lock is set only by a serially started join and is
    // released when the engine drops busy, whatever the join outcome;
    // the role flag is captured at the start so a later change of the
    // key receiver flag does not alter a join already under way
    // join ownership and role capture
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_join_q     <= 1'b0;
            busy_q            <= 1'b0;
            join_admin_role_q <= 1'b0;
        end else begin
            busy_q <= join_busy_i;
            if (join_start_o) begin
                join_admin_role_q <= !key_receiver_flag_i;
            end
            if (take && state_q == SPCMD_JSUB &&
                wr_i.data == SPCMD_JOIN_RUN) begin
                serial_join_q <= 1'b1;
            end else if (busy_q && !join_busy_i) begin
                serial_join_q <= 1'b0;
            end
        end
    end

    // key storage; runtime copy reloads from the stored key after reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rkey_q          <= SPCMD_KEY_ZERO;
            skey_q          <= SPCMD_KEY_ZERO;
            shift_q         <= SPCMD_KEY_ZERO;
            loaded_q        <= 1'b0;
            stored_key_we_o <= 1'b0;
        end else begin
            stored_key_we_o <= 1'b0;
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                skey_q   <= stored_key_i;
                rkey_q   <= stored_key_i;
            end else if (take && state_q == SPCMD_KDATA) begin
                // first key byte ends up in the top byte
                shift_q <= {shift_q[119:0], wr_i.data};
                if (cnt_q == SPCMD_KEY_LAST) begin
                    if (sel_q == SPCMD_SEL_RUNTIME) begin
                        rkey_q <= {shift_q[119:0], wr_i.data};
                    end else begin
                        skey_q          <= {shift_q[119:0], wr_i.data};
                        stored_key_we_o <= 1'b1;
                    end
                end
            end else if (take && state_q == SPCMD_CSEL) begin
                if (wr_i.data == SPCMD_SEL_RUNTIME) begin
                    rkey_q <= SPCMD_KEY_ZERO;
                end else if (wr_i.data == SPCMD_SEL_STORED) begin
                    skey_q          <= SPCMD_KEY_ZERO;
                    stored_key_we_o <= 1'b1;
                end
            end else if (take && state_q == SPCMD_IDLE &&
                         wr_i.data == SPCMD_KEY_RELOAD) begin
                rkey_q <= skey_q;
            end else if (restore_go) begin
                skey_q          <= SPCMD_KEY_ZERO;
                stored_key_we_o <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// [rtl/spcmd_pkg.sv]
// package for the special command decoder: codes, layouts and carriers
package spcmd_pkg;
    localparam logic [7:0] SPCMD_REG_ADDR      = 8'hc7;
    localparam logic [7:0] SPCMD_JOIN_CTRL     = 8'h10;
    localparam logic [7:0] SPCMD_KEY_WRITE     = 8'h11;
    localparam logic [7:0] SPCMD_KEY_CLEAR     = 8'h12;
    localparam logic [7:0] SPCMD_KEY_RELOAD    = 8'h13;
    localparam logic [7:0] SPCMD_RESTORE_0     = 8'h20;
    localparam logic [7:0] SPCMD_RESTORE_1     = 8'haa;
    localparam logic [7:0] SPCMD_RESTORE_2     = 8'hbb;
    localparam logic [7:0] SPCMD_JOIN_HALT     = 8'h00;
    localparam logic [7:0] SPCMD_JOIN_ADMIN    = 8'h01;
    localparam logic [7:0] SPCMD_JOIN_RUN      = 8'h02;
    localparam logic [7:0] SPCMD_SEL_RUNTIME   = 8'h01;
    localparam logic [7:0] SPCMD_SEL_STORED    = 8'h02;
    localparam int         SPCMD_KEY_BYTES     = 16;
    localparam logic [4:0] SPCMD_KEY_LAST      = 5'h0f;
    localparam int         SPCMD_MSG_LEN       = 23;
    localparam logic [4:0] SPCMD_MSG_LAST      = 5'h16;
    localparam logic [127:0] SPCMD_KEY_ZERO    = 128'h0;

    // one register write as handed over by the frame parser
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
        logic       last;
    } spcmd_wr_s;

    typedef enum logic [7:0] {
        SPCMD_IDLE    = 8'b0000_0001,
        SPCMD_JSUB    = 8'b0000_0010,
        SPCMD_KSEL    = 8'b0000_0100,
        SPCMD_KDATA   = 8'b0000_1000,
        SPCMD_CSEL    = 8'b0001_0000,
        SPCMD_RST1    = 8'b0010_0000,
        SPCMD_RST2    = 8'b0100_0000,
        SPCMD_MSG     = 8'b1000_0000
    } spcmd_state_e;
endpackage

// [bench/spcmd_decoder_asserts.sv]
// checker for the special command decoder ports
`timescale 1ns/1ps
`default_nettype none
module spcmd_decoder_asserts
    import spcmd_pkg::*;
(
    // clock, reset and inputs
    input wire logic sys_clk_i, rst_i, key_receiver_flag_i, join_busy_i,
    input wire spcmd_pkg::spcmd_wr_s wr_i,
    input wire logic tx_ready_i, pb_restore_raw_i,
    // observed outputs
    input wire logic wr_reject_o, ack_o, join_start_o, join_halt_o,
    input wire logic join_as_admin_o, addr_copy_o, nv_restore_o,
    input wire logic tx_valid_o, sys_reset_o, stored_key_we_o,
    input wire logic runtime_key_set_o,
    input wire logic [7:0] tx_data_o,
    input wire logic [127:0] stored_key_o, runtime_key_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_addr: assert property (ack_o |-> wr_i.valid &&
        wr_i.addr == SPCMD_REG_ADDR) else $error("ack without write");
    chk_reject_busy: assert property (wr_reject_o |-> join_busy_i &&
        wr_i.valid && !ack_o) else $error("reject while idle");
    chk_start_cmd: assert property (join_start_o |-> !join_busy_i &&
        (!ack_o || wr_i.data == SPCMD_JOIN_RUN))
        else $error("start on wrong byte");
    chk_start_role: assert property (join_start_o |=>
        join_as_admin_o == !$past(key_receiver_flag_i))
        else $error("role not taken from flag");
    chk_halt_ack: assert property (join_halt_o |-> ack_o &&
        wr_i.data == SPCMD_JOIN_HALT) else $error("halt not with ack");
    chk_copy_after: assert property (addr_copy_o |-> !join_busy_i &&
        ($past(join_busy_i) || $past(join_busy_i, 2)))
        else $error("address copy not after join end");
    chk_restore_seq: assert property (nv_restore_o |-> (ack_o &&
        wr_i.data == SPCMD_RESTORE_2) || $past(pb_restore_raw_i, 2))
        else $error("restore on wrong byte");
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o)) else $error("tx byte dropped");
    chk_reset_late: assert property (sys_reset_o |->
        $past(tx_valid_o && tx_ready_i)) else $error("reset too early");
    chk_key_change: assert property (stored_key_we_o |->
        stored_key_o != $past(stored_key_o)) else $error("write no change");
    chk_key_zero: assert property (runtime_key_set_o ==
        (runtime_key_o != SPCMD_KEY_ZERO)) else $error("key set flag wrong");
endmodule
bind spcmd_decoder spcmd_decoder_asserts u_chk (.sys_clk_i, .rst_i,
    .key_receiver_flag_i, .join_busy_i, .wr_i, .tx_ready_i,
    .pb_restore_raw_i, .wr_reject_o,
    .ack_o, .join_start_o, .join_halt_o, .join_as_admin_o, .addr_copy_o,
    .nv_restore_o, .tx_valid_o, .sys_reset_o, .stored_key_we_o,
    .runtime_key_set_o, .tx_data_o, .stored_key_o, .runtime_key_o);
`default_nettype wire

// [bench/spcmd_host_model.sv]
// host model: sends command bytes and reads back the reply text
`timescale 1ns/1ps
`default_nettype none
module spcmd_host_model (
    // clock and reply text
    input  wire logic                 sys_clk_i,
    input  wire logic                 tx_valid_i,
    input  wire logic [7:0]           tx_data_i,
    // command writes and reply pacing
    output var spcmd_pkg::spcmd_wr_s  wr_o,
    output logic                      tx_ready_o
);
    logic [7:0] msg [0:31];
    int         n = 0;
    initial begin
        wr_o = '0;
        tx_ready_o = 1'b0;
    end
    // one byte a call, held until the edge that takes it
    task automatic send(input logic [7:0] a, d, input logic l);
        wr_o <= '{1'b1, a, d, l};
        @(posedge sys_clk_i);
    endtask
    // released bus shows inverted data so stale bytes never match
    task automatic idle;
        wr_o <= '{1'b0, ~wr_o.addr, ~wr_o.data, 1'b0};
        @(posedge sys_clk_i);
    endtask
    // slow reader: ready toggles, so each byte has to wait
    always @(posedge sys_clk_i) begin
        tx_ready_o <= ~tx_ready_o;
        if (tx_valid_i && tx_ready_o) begin
            msg[n] <= tx_data_i;
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

// [bench/spcmd_decoder_tb.sv]
// testbench for the special command decoder
`timescale 1ns/1ps
`default_nettype none
module spcmd_decoder_tb;
    import spcmd_pkg::*;
    localparam logic [127:0] K0 = 128'h0123456789abcdef_0f1e2d3c4b5a6978;
    localparam logic [127:0] K1 = 128'hfedcba9876543210_a5a55a5a3c3cc3c3;
    localparam logic [127:0] K2 = 128'h1122334455667788_99aabbccddeeff01;
    localparam logic [183:0] TXT = "\r\nConfiguration Reset\r\n";
    logic sys_clk_i = 0, rst_i = 1, pb_join_raw_i = 0, pb_restore_raw_i = 0;
    logic key_receiver_flag_i = 1, join_busy_i = 0, join_ok_i = 0;
    logic [127:0] stored_key_i = K0, stored_key_o, runtime_key_o;
    spcmd_wr_s wr_i;
    logic wr_reject_o, ack_o, join_halt_o, join_admin_o, join_start_o;
    logic join_as_admin_o, addr_copy_o, stored_key_we_o, runtime_key_set_o;
    logic stored_key_set_o, nv_restore_o, tx_valid_o, sys_reset_o, tx_ready_i;
    logic [7:0] tx_data_o;
    int cnt [7];
    int bad_count = 0, checked = 0, cyc = 0;
    spcmd_decoder uut (.*);
    spcmd_host_model host (.sys_clk_i, .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .wr_o(wr_i), .tx_ready_o(tx_ready_i));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    // pulse counters and a hang guard
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 7; i++) cnt[i] += {sys_reset_o, nv_restore_o,
            addr_copy_o, join_admin_o, join_halt_o, join_start_o,
            wr_reject_o} >> i & 1;
        if (++cyc == 5000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    task automatic cmp_k(input string s, input logic [127:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic cmp_b(input string s, input logic [7:0] e, g);
        cmp_k(s, {120'h0, e}, {120'h0, g});
    endtask
    task automatic cmd2(input logic [7:0] a, b);
        host.send(SPCMD_REG_ADDR, a, 1'b0);
        host.send(SPCMD_REG_ADDR, b, 1'b1);
        host.idle;
    endtask
    task automatic wkey(input logic [7:0] sel, input logic [127:0] k);
        host.send(SPCMD_REG_ADDR, SPCMD_KEY_WRITE, 1'b0);
        host.send(SPCMD_REG_ADDR, sel, 1'b0);
        for (int i = 0; i < 16; i++)
            host.send(SPCMD_REG_ADDR, k[127-8*i -: 8], i == 15);
        host.idle;
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        cmp_k("runtime key", K0, runtime_key_o);
        wkey(SPCMD_SEL_RUNTIME, K1);
        cmp_k("runtime key", K1, runtime_key_o);
        wkey(SPCMD_SEL_STORED, K2);
        cmp_k("stored key", K2, stored_key_o);
        cmd2(SPCMD_KEY_CLEAR, 8'h03);
        cmp_k("runtime key", K1, runtime_key_o);
        cmd2(SPCMD_KEY_CLEAR, SPCMD_SEL_RUNTIME);
        cmp_k("runtime key", '0, runtime_key_o);
        cmp_b("key set", 8'h00, {7'h0, runtime_key_set_o});
        host.send(SPCMD_REG_ADDR, SPCMD_KEY_RELOAD, 1'b1);
        host.idle;
        cmp_k("runtime key", K2, runtime_key_o);
        host.send(8'hc6, SPCMD_KEY_CLEAR, 1'b0);
        host.send(8'hc6, SPCMD_SEL_STORED, 1'b1);
        cmd2(8'h55, SPCMD_SEL_STORED);
        cmp_k("stored key", K2, stored_key_o);
        cmd2(SPCMD_KEY_CLEAR, SPCMD_SEL_STORED);
        cmp_b("stored set", 8'h00, {7'h0, stored_key_set_o});
        cmd2(SPCMD_JOIN_CTRL, SPCMD_JOIN_ADMIN);
        cmp_b("admin", 8'h01, 8'(cnt[3]));
        cmd2(SPCMD_JOIN_CTRL, SPCMD_JOIN_RUN);
        cmp_b("as admin", 8'h00, {7'h0, join_as_admin_o});
        join_busy_i <= 1'b1;
        pb_join_raw_i <= 1'b1;
        host.send(SPCMD_REG_ADDR, SPCMD_KEY_RELOAD, 1'b1);
        host.idle;
        cmp_b("reject", 8'h01, 8'(cnt[0]));
        cmd2(SPCMD_JOIN_CTRL, SPCMD_JOIN_HALT);
        cmp_b("halt", 8'h01, 8'(cnt[2]));
        cmp_b("start", 8'h01, 8'(cnt[1]));
        join_ok_i <= 1'b1;
        join_busy_i <= 1'b0;
        pb_join_raw_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        cmp_b("copy", 8'h01, 8'(cnt[4]));
        pb_join_raw_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        cmp_b("start", 8'h02, 8'(cnt[1]));
        wkey(SPCMD_SEL_STORED, K1);
        cmp_k("stored key", K1, stored_key_o);
        host.send(SPCMD_REG_ADDR, SPCMD_RESTORE_0, 1'b0);
        host.send(SPCMD_REG_ADDR, SPCMD_RESTORE_1, 1'b0);
        host.send(SPCMD_REG_ADDR, 8'h00, 1'b1);
        cmp_b("restore", 8'h00, 8'(cnt[5]));
        host.send(SPCMD_REG_ADDR, SPCMD_RESTORE_0, 1'b0);
        host.send(SPCMD_REG_ADDR, SPCMD_RESTORE_1, 1'b0);
        host.send(SPCMD_REG_ADDR, SPCMD_RESTORE_2, 1'b1);
        host.idle;
        for (int i = 0; i < 200 && cnt[6] == 0; i++) @(posedge sys_clk_i);
        cmp_b("restore", 8'h01, 8'(cnt[5]));
        cmp_b("sys reset", 8'h01, 8'(cnt[6]));
        cmp_k("stored key", '0, stored_key_o);
        repeat (60) @(posedge sys_clk_i);
        cmp_b("sys reset", 8'h01, 8'(cnt[6]));
        for (int i = 0; i < 23; i++)
            cmp_b("text", TXT[183-8*i -: 8], host.msg[i]);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        pb_restore_raw_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        pb_restore_raw_i <= 1'b0;
        cmp_b("restore", 8'h02, 8'(cnt[5]));
        cmp_k("stored key", '0, stored_key_o);
        tally_and_finish;
    end
endmodule
`default_nettype wire
